// >>> shared/sata_pm_pkg.sv
package sata_pm_pkg;
	localparam int         PORTS            = 3;
	localparam int         TW               = 32;
	localparam int         STATE_W          = 3;
	localparam int         CLK_PERIOD_PS    = 10000;
	localparam int         PS_PER_NS        = 1000;
	localparam int         PS_PER_MS        = 1000000000;
	localparam int         PARTIAL_EXIT_NS  = 10;
	localparam int         SLUMBER_EXIT_MS  = 10;
	localparam int         DEVSLP_EXIT_MS   = 20;
	localparam int         PARTIAL_EXIT_RAW = PARTIAL_EXIT_NS * PS_PER_NS / CLK_PERIOD_PS;
	localparam int         PARTIAL_EXIT_CYC = (PARTIAL_EXIT_RAW < 1) ? 1 : PARTIAL_EXIT_RAW;
	localparam int         CYC_PER_MS       = PS_PER_MS / CLK_PERIOD_PS;
	localparam int         SLUMBER_EXIT_CYC = SLUMBER_EXIT_MS * CYC_PER_MS;
	localparam logic [7:0] DEVSLP_EXIT_RST  = 8'(DEVSLP_EXIT_MS);

	localparam logic [7:0] ADDR_PM_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_MODE        = 8'h04;
	localparam logic [7:0] ADDR_PORT_CS     = 8'h08;
	localparam logic [7:0] ADDR_LINK_CTRL   = 8'h40;
	localparam logic [7:0] ADDR_LINK_CMD    = 8'h44;
	localparam logic [7:0] ADDR_LINK_STAT   = 8'h48;
	localparam logic [7:0] ADDR_DEVSLP_TMO  = 8'h4C;
	localparam logic [7:0] ADDR_DPG         = 8'h50;

	localparam int         PM_STATE_W       = 2;
	localparam int         MODE_RAID_BIT    = 0;
	localparam int         MODE_ALT_ID_BIT  = 7;
	localparam int         MODE_AVAIL_BIT   = 8;
	localparam int         PCS_PRESENT_LSB  = 8;
	localparam int         CTRL_LOW_PWR_BIT = 8;
	localparam int         CTRL_INT_EN_BIT  = 9;
	localparam int         STAT_TMO_LSB     = 16;
	localparam int         STAT_BUSY_LSB    = 24;
	localparam int         DEVICE_SLEEP_EXIT_TIMEOUT_W           = 8;

	localparam logic [1:0] PM_D0            = 2'h0;
	localparam logic [1:0] PM_D3            = 2'h3;
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLVERR      = 2'h2;
	localparam logic [1:0] RESP_DECODE      = 2'h3;

	typedef enum logic [STATE_W-1:0] {
		LINK_ACTIVE   = 3'h0,
		LINK_PARTIAL  = 3'h1,
		LINK_SLUMBER  = 3'h3,
		LINK_DEVSLEEP = 3'h2,
		LINK_WAKE     = 3'h6
	} link_state_t;

	typedef struct packed {
		logic req_partial;
		logic req_slumber;
		logic rx_comwake;
		logic phy_ready;
		logic attached;
	} phy_in_t;

	typedef struct packed {
		logic pm_ack;
		logic tx_comwake;
		logic devslp;
		logic power_gate;
		logic oob_off;
	} phy_out_t;

	typedef struct packed {
		link_state_t   state;
		logic          pend;
		logic          from_ds;
		logic [TW-1:0] cnt;
		logic [TW-1:0] limit;
		logic          timeout;
		phy_out_t      out;
	} port_regs_t;

	typedef struct packed {
		logic out;
		logic oe_n;
	} led_t;

	typedef struct packed {
		logic              waitrequest;
		logic [31:0]       readdata;
		logic [1:0]        response;
		logic [1:0]        pm_state;
		logic              raid_mode;
		logic              alt_id;
		logic              raid_avail;
		logic [PORTS-1:0]  port_en;
		logic [PORTS-1:0]  dpg_en;
		logic [PORTS-1:0]  devslp_en;
		logic [PORTS-1:0]  host_need;
		logic [PORTS-1:0]  tmo_flag;
		logic              low_power;
		logic              int_en;
		logic [DEVICE_SLEEP_EXIT_TIMEOUT_W-1:0] device_sleep_exit_timeout;
		logic              irq;
	} regs_t;
endpackage

// >>> hdl/link_pm_port.sv
`timescale 1ns/100ps
`default_nettype none
module link_pm_port (
	input  wire logic                     sys_clk,
	input  wire logic                     resetn,
	input  wire logic                     enable,
	input  wire logic                     d3,
	input  wire logic                     low_power,
	input  wire logic                     dpg_en,
	input  wire logic                     devslp_en,
	input  wire logic                     host_need,
	input  wire logic [sata_pm_pkg::TW-1:0] slumber_limit,
	input  wire logic [sata_pm_pkg::TW-1:0] devslp_limit,
	input  wire sata_pm_pkg::phy_in_t     phy_rx,
	output var  sata_pm_pkg::phy_out_t    phy_tx,
	output var  sata_pm_pkg::link_state_t state,
	output logic                          timeout
);
	import sata_pm_pkg::*;

	localparam logic [TW-1:0] PARTIAL_LIMIT = TW'(PARTIAL_EXIT_CYC);

	port_regs_t r;
	port_regs_t next_r;

	always_comb begin
		next_r = r;
		next_r.out.pm_ack = 1'b0;
		next_r.out.tx_comwake = 1'b0;
		next_r.timeout = 1'b0;
		if (host_need) begin
			next_r.pend = 1'b1;
		end
		if (!enable || d3) begin
			next_r.state = LINK_ACTIVE;
			next_r.pend = 1'b0;
			next_r.from_ds = 1'b0;
			next_r.out.devslp = 1'b0;
		end else begin
			unique case (r.state)
				LINK_ACTIVE: begin
					next_r.pend = 1'b0;
					if (phy_rx.req_partial || phy_rx.req_slumber) begin
						next_r.out.pm_ack = 1'b1;
						next_r.state = phy_rx.req_slumber ? LINK_SLUMBER : LINK_PARTIAL;
					end
				end
				LINK_PARTIAL: begin
					if (r.pend || host_need || phy_rx.rx_comwake) begin
						next_r.out.tx_comwake = r.pend || host_need;
						next_r.pend = 1'b0;
						next_r.cnt = '0;
						next_r.limit = PARTIAL_LIMIT;
						next_r.state = LINK_WAKE;
					end
				end
				LINK_SLUMBER: begin
					if (r.pend || host_need || (phy_rx.rx_comwake && !low_power)) begin
						next_r.out.tx_comwake = r.pend || host_need;
						next_r.pend = 1'b0;
						next_r.cnt = '0;
						next_r.limit = r.from_ds ? r.limit : slumber_limit;
						next_r.from_ds = 1'b0;
						next_r.state = LINK_WAKE;
					end else if (devslp_en) begin
						next_r.out.devslp = 1'b1;
						next_r.state = LINK_DEVSLEEP;
					end
				end
				LINK_DEVSLEEP: begin
					if (r.pend || host_need || !devslp_en) begin
						next_r.out.devslp = 1'b0;
						next_r.from_ds = 1'b1;
						next_r.limit = devslp_limit;
						next_r.state = LINK_SLUMBER;
					end
				end
				LINK_WAKE: begin
					if (phy_rx.phy_ready) begin
						next_r.state = LINK_ACTIVE;
					end else if (r.cnt != r.limit) begin
						next_r.cnt = r.cnt + 1'b1;
					end else begin
						next_r.timeout = 1'b1;
						next_r.state = LINK_ACTIVE;
					end
				end
				default: begin
					next_r.state = LINK_ACTIVE;
				end
			endcase
		end
		next_r.out.power_gate = d3 || (dpg_en && (next_r.state == LINK_SLUMBER ||
			next_r.state == LINK_DEVSLEEP));
		next_r.out.oob_off = d3 || (low_power && next_r.state == LINK_SLUMBER);
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign phy_tx = r.out;
	assign state = r.state;
	assign timeout = r.timeout;
endmodule // link_pm_port
`default_nettype wire

// >>> hdl/activity_led.sv
`timescale 1ns/100ps
`default_nettype none
module activity_led (
	input  wire logic                          sys_clk,
	input  wire logic                          resetn,
	input  wire logic [sata_pm_pkg::PORTS-1:0] port_busy_bit,
	output logic                               led_o,
	output logic                               led_oe_n
);
	import sata_pm_pkg::*;

	led_t r;
	led_t next_r;

	always_comb begin
		next_r = r;
		next_r.out = 1'b0;
		next_r.oe_n = !(|port_busy_bit);
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '{out: 1'b0, oe_n: 1'b1};
		end else begin
			r <= next_r;
		end
	end

	assign led_o = r.out;
	assign led_oe_n = r.oe_n;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_led_on_busy: assert property (|port_busy_bit |=> !led_oe_n && !led_o)
		else $error("activity led not driven low while a port is busy");
	a_led_release: assert property (!(|port_busy_bit) |=> led_oe_n)
		else $error("activity led still driven with no port busy");
endmodule // activity_led
`default_nettype wire

// >>> hdl/sata_link_power_presence_led.sv
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sata_link_power_presence_led #(
	parameter int CYC_PER_MS_P       = sata_pm_pkg::CYC_PER_MS,
	parameter int SLUMBER_EXIT_CYC_P = sata_pm_pkg::SLUMBER_EXIT_CYC
) (
	input  wire logic                              sys_clk,
	input  wire logic                              resetn,
	input  wire logic [7:0]                        avs_address,
	input  wire logic                              avs_read,
	input  wire logic                              avs_write,
	input  wire logic [31:0]                       avs_writedata,
	input  wire logic [3:0]                        avs_byteenable,
	output logic [31:0]                            avs_readdata,
	output logic                                   avs_waitrequest,
	output logic [1:0]                             avs_response,
	input  wire sata_pm_pkg::phy_in_t [sata_pm_pkg::PORTS-1:0]  phy_rx,
	output var  sata_pm_pkg::phy_out_t [sata_pm_pkg::PORTS-1:0] phy_tx,
	input  wire logic [sata_pm_pkg::PORTS-1:0]     port_busy_bit,
	input  wire logic                              intr_pending,
	output logic                                   irq,
	output logic                                   raid_available,
	output logic                                   activity_led_n_o,
	output logic                                   activity_led_n_oe_n
);
	import sata_pm_pkg::*;

	localparam logic [TW-1:0] SLUMBER_LIMIT = TW'(SLUMBER_EXIT_CYC_P);
	localparam logic [TW-1:0] MS_CYCLES     = TW'(CYC_PER_MS_P);

	regs_t            r;
	regs_t            next_r;
	link_state_t      port_state [PORTS];
	logic [PORTS-1:0] tmo_pulse;
	logic [PORTS-1:0] present;
	logic [TW-1:0]    devslp_limit;
	logic             pm_d3;
	logic [31:0]      view;
	logic [31:0]      wword;
	logic [31:0]      wmask;
	logic             wr_go;
	logic             mem_ok;

	function automatic logic is_cfg(input logic [7:0] a);
		return a == ADDR_PM_CTRL || a == ADDR_MODE || a == ADDR_PORT_CS || a == ADDR_DPG;
	endfunction

	function automatic logic is_mem(input logic [7:0] a);
		return a == ADDR_LINK_CTRL || a == ADDR_LINK_CMD || a == ADDR_LINK_STAT ||
			a == ADDR_DEVSLP_TMO;
	endfunction

	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{be[b]}};
		end
		return m;
	endfunction

	assign pm_d3 = r.pm_state == PM_D3;
	assign devslp_limit = TW'((r.device_sleep_exit_timeout == '0) ? DEVSLP_EXIT_RST : r.device_sleep_exit_timeout) * MS_CYCLES;

	always_comb begin
		for (int i = 0; i < PORTS; i++) begin
			present[i] = phy_rx[i].attached && r.port_en[i] && !pm_d3;
		end
	end

	always_comb begin
		view = '0;
		case (avs_address)
			ADDR_PM_CTRL: begin
				view[PM_STATE_W-1:0] = r.pm_state;
			end
			ADDR_MODE: begin
				view[MODE_RAID_BIT] = r.raid_mode;
				view[MODE_ALT_ID_BIT] = r.alt_id;
				view[MODE_AVAIL_BIT] = r.raid_avail;
			end
			ADDR_PORT_CS: begin
				view[PORTS-1:0] = r.port_en;
				view[PCS_PRESENT_LSB +: PORTS] = present;
			end
			ADDR_DPG: begin
				view[PORTS-1:0] = r.dpg_en;
			end
			ADDR_LINK_CTRL: begin
				view[PORTS-1:0] = r.devslp_en;
				view[CTRL_LOW_PWR_BIT] = r.low_power;
				view[CTRL_INT_EN_BIT] = r.int_en;
			end
			ADDR_LINK_STAT: begin
				for (int i = 0; i < PORTS; i++) begin
					view[i*STATE_W +: STATE_W] = port_state[i];
				end
				view[STAT_TMO_LSB +: PORTS] = r.tmo_flag;
				view[STAT_BUSY_LSB +: PORTS] = port_busy_bit;
			end
			ADDR_DEVSLP_TMO: begin
				view[DEVICE_SLEEP_EXIT_TIMEOUT_W-1:0] = r.device_sleep_exit_timeout;
			end
			default: begin
				view = '0;
			end
		endcase
	end

	always_comb begin
		next_r = r;
		next_r.host_need = '0;
		next_r.waitrequest = 1'b1;
		wmask = lane_mask(avs_byteenable);
		wword = (view & ~wmask) | (avs_writedata & wmask);
		mem_ok = is_mem(avs_address) && !pm_d3;
		wr_go = avs_write && !r.waitrequest && (is_cfg(avs_address) || mem_ok);
		if ((avs_read || avs_write) && r.waitrequest) begin
			next_r.waitrequest = 1'b0;
			next_r.readdata = '0;
			if (is_cfg(avs_address) || mem_ok) begin
				next_r.response = RESP_OKAY;
				if (avs_read) begin
					next_r.readdata = view;
				end
			end else if (is_mem(avs_address)) begin
				next_r.response = RESP_SLVERR;
			end else begin
				next_r.response = RESP_DECODE;
			end
		end
		next_r.tmo_flag = r.tmo_flag | tmo_pulse;
		if (wr_go) begin
			case (avs_address)
				ADDR_PM_CTRL: begin
					next_r.pm_state = wword[PM_STATE_W-1:0];
				end
				ADDR_MODE: begin
					next_r.raid_mode = wword[MODE_RAID_BIT];
					next_r.alt_id = wword[MODE_ALT_ID_BIT];
				end
				ADDR_PORT_CS: begin
					next_r.port_en = wword[PORTS-1:0];
				end
				ADDR_DPG: begin
					next_r.dpg_en = wword[PORTS-1:0];
				end
				ADDR_LINK_CTRL: begin
					next_r.devslp_en = wword[PORTS-1:0];
					next_r.low_power = wword[CTRL_LOW_PWR_BIT];
					next_r.int_en = wword[CTRL_INT_EN_BIT];
				end
				ADDR_LINK_CMD: begin
					next_r.host_need = wword[PORTS-1:0] & r.port_en;
				end
				ADDR_LINK_STAT: begin
					next_r.tmo_flag = (r.tmo_flag & ~(avs_writedata[STAT_TMO_LSB +: PORTS] &
						wmask[STAT_TMO_LSB +: PORTS])) | tmo_pulse;
				end
				ADDR_DEVSLP_TMO: begin
					next_r.device_sleep_exit_timeout = wword[DEVICE_SLEEP_EXIT_TIMEOUT_W-1:0];
				end
				default: begin
					next_r.host_need = '0;
				end
			endcase
		end
		next_r.irq = intr_pending && r.int_en && !pm_d3;
		next_r.raid_avail = r.raid_mode && !r.alt_id;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '{waitrequest: 1'b1, device_sleep_exit_timeout: DEVSLP_EXIT_RST, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign avs_readdata = r.readdata;
	assign avs_waitrequest = r.waitrequest;
	assign avs_response = r.response;
	assign irq = r.irq;
	assign raid_available = r.raid_avail;

	activity_led u_led (
		.sys_clk       (sys_clk),
		.resetn        (resetn),
		.port_busy_bit (port_busy_bit),
		.led_o         (activity_led_n_o),
		.led_oe_n      (activity_led_n_oe_n)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence

	sequence s_mode_block;
		avs_write && !avs_waitrequest && avs_address == ADDR_MODE && avs_byteenable[0] &&
			avs_writedata[MODE_RAID_BIT] && avs_writedata[MODE_ALT_ID_BIT] && !pm_d3;
	endsequence

	for (genvar i = 0; i < PORTS; i++) begin : g_port
		link_pm_port u_port (
			.sys_clk       (sys_clk),
			.resetn        (resetn),
			.enable        (r.port_en[i]),
			.d3            (pm_d3),
			.low_power     (r.low_power),
			.dpg_en        (r.dpg_en[i]),
			.devslp_en     (r.devslp_en[i]),
			.host_need     (r.host_need[i]),
			.slumber_limit (SLUMBER_LIMIT),
			.devslp_limit  (devslp_limit),
			.phy_rx        (phy_rx[i]),
			.phy_tx        (phy_tx[i]),
			.state         (port_state[i]),
			.timeout       (tmo_pulse[i])
		);

		sequence s_need_partial;
			r.host_need[i] && port_state[i] == LINK_PARTIAL && r.port_en[i] && !pm_d3;
		endsequence

		sequence s_partial_wake;
			port_state[i] == LINK_PARTIAL ##1 port_state[i] == LINK_WAKE;
		endsequence

		a_pm_ack_slumber: assert property (phy_rx[i].req_slumber &&
			port_state[i] == LINK_ACTIVE && r.port_en[i] && !pm_d3 |=>
			phy_tx[i].pm_ack && port_state[i] == LINK_SLUMBER)
			else $error("drive slumber request not acknowledged");
		a_no_host_entry: assert property (port_state[i] == LINK_ACTIVE &&
			!phy_rx[i].req_partial && !phy_rx[i].req_slumber |=>
			port_state[i] != LINK_PARTIAL && port_state[i] != LINK_SLUMBER)
			else $error("link entered low power without a drive request");
		a_wake_partial: assert property (s_need_partial |=>
			phy_tx[i].tx_comwake && port_state[i] == LINK_WAKE)
			else $error("no comwake for host need in partial");
		a_partial_exit: assert property (s_partial_wake |-> ##[1:2]
			port_state[i] != LINK_WAKE)
			else $error("partial exit took too long");
		a_devslp_slumber: assert property ($rose(phy_tx[i].devslp) |->
			$past(port_state[i]) == LINK_SLUMBER && port_state[i] == LINK_DEVSLEEP)
			else $error("device sleep raised outside slumber");
		a_oob_low_power: assert property (port_state[i] == LINK_SLUMBER &&
			$past(r.low_power) |-> phy_tx[i].oob_off)
			else $error("oob detection left on in low power slumber");
		a_d3_gate: assert property (pm_d3 |=> phy_tx[i].power_gate &&
			port_state[i] == LINK_ACTIVE && !phy_tx[i].devslp)
			else $error("port not shut down in d3");
	end

	a_bus_answer: assert property (s_req_wait |=> !avs_waitrequest)
		else $error("bus request not answered in one cycle");
	a_mem_abort: assert property ((s_req_wait and (is_mem(avs_address) && pm_d3)) |=>
		avs_response == RESP_SLVERR && avs_readdata == '0)
		else $error("memory access in d3 not aborted");
	a_irq_blocked: assert property (pm_d3 |=> !irq)
		else $error("interrupt raised in d3");
	a_irq_resume: assert property (intr_pending && r.int_en && !pm_d3 |=> irq)
		else $error("pending interrupt not raised in d0");
	a_d3_keep: assert property (avs_write && !avs_waitrequest &&
		avs_address == ADDR_PM_CTRL |=> $stable(r.port_en) && $stable(r.device_sleep_exit_timeout) &&
		$stable(r.dpg_en))
		else $error("power state change disturbed registers");
	a_present_d3: assert property ((s_req_wait and (avs_read && avs_address == ADDR_PORT_CS &&
		pm_d3)) |=> avs_readdata[PCS_PRESENT_LSB +: PORTS] == '0)
		else $error("present bits set while in d3");
	a_raid_block: assert property (s_mode_block |=> ##1 !raid_available)
		else $error("raid available with alternate id set");
endmodule // sata_link_power_presence_led
`default_nettype wire

// >>> testbench/drive_model.sv
`timescale 1ns/100ps
`default_nettype none
module drive_model #(
	parameter int DLY = 4
) (
	input  wire logic                                 sys_clk,
	input  wire logic                                 resetn,
	input  wire logic [sata_pm_pkg::PORTS-1:0]        attached,
	input  wire logic [3*sata_pm_pkg::PORTS-1:0]      want,
	input  wire sata_pm_pkg::phy_out_t [sata_pm_pkg::PORTS-1:0] phy_tx,
	output var  sata_pm_pkg::phy_in_t [sata_pm_pkg::PORTS-1:0]  phy_rx
);
	import sata_pm_pkg::*;
	logic [PORTS-1:0] rdy;
	int               wcnt [PORTS];
	// Ready drops on entry to low power, returns a port-dependent delay after a wake
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdy  <= '1;
			wcnt <= '{default: 0};
		end else begin
			for (int i = 0; i < PORTS; i++) begin
				if (phy_tx[i].pm_ack)
					rdy[i] <= 1'b0;
				if (phy_tx[i].tx_comwake || want[2*PORTS+i])
					wcnt[i] <= DLY * (i + 1);
				else if (wcnt[i] == 1) begin
					rdy[i]  <= 1'b1;
					wcnt[i] <= 0;
				end else if (wcnt[i] != 0)
					wcnt[i] <= wcnt[i] - 1;
			end
		end
	end
	// Wake pulses only on bench command; no COMINIT path exists
	always_comb begin
		for (int i = 0; i < PORTS; i++)
			phy_rx[i] = '{want[i], want[PORTS+i], want[2*PORTS+i], rdy[i], attached[i]};
	end
endmodule // drive_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import sata_pm_pkg::*;
	logic                 sys_clk;
	logic                 resetn;
	logic [7:0]           avs_address;
	logic                 avs_read;
	logic                 avs_write;
	logic [31:0]          avs_writedata;
	logic [31:0]          avs_readdata;
	logic                 avs_waitrequest;
	logic [1:0]           avs_response;
	phy_in_t [PORTS-1:0]  phy_rx;
	phy_out_t [PORTS-1:0] phy_tx;
	logic [PORTS-1:0]     busy;
	logic [PORTS-1:0]     attached;
	logic [3*PORTS-1:0]   want;
	logic                 intr_pending;
	logic                 irq;
	logic                 raid_available;
	logic                 led_o;
	logic                 led_oe_n;
	int                   n_errors;
	int                   num_checks;
	int                   n;
	logic [31:0]          r;
	logic [31:0]          modes [4] = '{32'h0, 32'h1, 32'h80, 32'h81};

	sata_link_power_presence_led #(
		.CYC_PER_MS_P       (10),
		.SLUMBER_EXIT_CYC_P (50)
	) i_sata_link_power_presence_led (
		.sys_clk             (sys_clk),
		.resetn              (resetn),
		.avs_address         (avs_address),
		.avs_read            (avs_read),
		.avs_write           (avs_write),
		.avs_writedata       (avs_writedata),
		.avs_byteenable      (4'hF),
		.avs_readdata        (avs_readdata),
		.avs_waitrequest     (avs_waitrequest),
		.avs_response        (avs_response),
		.phy_rx              (phy_rx),
		.phy_tx              (phy_tx),
		.port_busy_bit       (busy),
		.intr_pending        (intr_pending),
		.irq                 (irq),
		.raid_available      (raid_available),
		.activity_led_n_o    (led_o),
		.activity_led_n_oe_n (led_oe_n)
	);

	drive_model i_drive_model (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.attached (attached),
		.want     (want),
		.phy_tx   (phy_tx),
		.phy_rx   (phy_rx)
	);

	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, s, e);
		end
	endtask

	function automatic logic [31:0] present_exp(input logic [2:0] a, input logic [2:0] e);
		return {21'h0, a & e, 5'h0, e};
	endfunction

	function automatic logic [31:0] raid_exp(input logic [31:0] v);
		return {23'h0, v[0] & ~v[7], 8'h0};
	endfunction

	// One Avalon access; checks masked read data and the response code
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		chk(avs_readdata & m, e);
		chk({30'h0, avs_response}, {30'h0, er});
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic pulse(input int b);
		@(posedge sys_clk);
		want[b] <= 1'b1;
		@(posedge sys_clk);
		want[b] <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic poll(input int p);
		n = 0;
		do begin
			acc(1'b0, ADDR_LINK_STAT, 32'h0, 32'h0, 32'h0, RESP_OKAY);
			n++;
		end while (avs_readdata[3*p+:3] !== 3'h0 && n < 40);
	endtask

	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		r = $urandom(32'h7C76);
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		{busy, attached, want, intr_pending} = '0;
		n_errors = 0;
		num_checks = 0;
		resetn = 1'b0;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		chk(led_oe_n, 1'b1);
		acc(1'b0, ADDR_DEVSLP_TMO, 32'h0, 32'hFF, 32'h14, RESP_OKAY);
		acc(1'b0, 8'h3C, 32'h0, 32'hFFFFFFFF, 32'h0, RESP_DECODE);
		r = $urandom;
		attached <= r[2:0];
		acc(1'b1, ADDR_PORT_CS, {29'h0, r[5:3]}, 32'h0, 32'h0, RESP_OKAY);
		acc(1'b0, ADDR_PORT_CS, 32'h0, 32'h707, present_exp(r[2:0], r[5:3]), RESP_OKAY);
		for (int k = 0; k < 12; k++) begin
			@(posedge sys_clk);
			busy <= (k < 2) ? 3'(k * 4) : 3'($urandom);
			@(posedge sys_clk);
			@(negedge sys_clk);
			chk(led_oe_n, busy == 3'h0);
			chk(led_o, 1'b0);
		end
		foreach (modes[k]) begin
			acc(1'b1, ADDR_MODE, modes[k], 32'h0, 32'h0, RESP_OKAY);
			acc(1'b0, ADDR_MODE, 32'h0, 32'h100, raid_exp(modes[k]), RESP_OKAY);
			chk(raid_available, raid_exp(modes[k]) >> 8);
		end
		r = $urandom;
		acc(1'b1, ADDR_DPG, r, 32'h0, 32'h0, RESP_OKAY);
		acc(1'b0, ADDR_DPG, 32'h0, 32'h7, r & 32'h7, RESP_OKAY);
		attached <= 3'h7;
		acc(1'b1, ADDR_PORT_CS, 32'h7, 32'h0, 32'h0, RESP_OKAY);
		acc(1'b1, ADDR_LINK_CTRL, 32'h1, 32'h0, 32'h0, RESP_OKAY);
		pulse(3);
		chk(phy_tx[0].pm_ack, 1'b1);
		acc(1'b0, ADDR_LINK_STAT, 32'h0, 32'h7, 32'h2, RESP_OKAY);
		chk(phy_tx[0].devslp, 1'b1);
		acc(1'b1, ADDR_LINK_CMD, 32'h1, 32'h0, 32'h0, RESP_OKAY);
		poll(0);
		chk(n < 10, 1'b1);
		acc(1'b0, ADDR_LINK_STAT, 32'h0, 32'h10000, 32'h0, RESP_OKAY);
		acc(1'b1, ADDR_LINK_CTRL, 32'h0, 32'h0, 32'h0, RESP_OKAY);
		pulse(1);
		chk(phy_tx[1].pm_ack, 1'b1);
		pulse(7);
		repeat (3) @(posedge sys_clk);
		acc(1'b0, ADDR_LINK_STAT, 32'h0, 32'h20038, 32'h20000, RESP_OKAY);
		acc(1'b1, ADDR_LINK_STAT, 32'h20000, 32'h0, 32'h0, RESP_OKAY);
		acc(1'b0, ADDR_LINK_STAT, 32'h0, 32'h20000, 32'h0, RESP_OKAY);
		acc(1'b1, ADDR_LINK_CTRL, 32'h100, 32'h0, 32'h0, RESP_OKAY);
		pulse(5);
		chk(phy_tx[2].pm_ack, 1'b1);
		pulse(8);
		acc(1'b0, ADDR_LINK_STAT, 32'h0, 32'h1C0, 32'hC0, RESP_OKAY);
		chk(phy_tx[2].oob_off, 1'b1);
		acc(1'b1, ADDR_LINK_CMD, 32'h4, 32'h0, 32'h0, RESP_OKAY);
		poll(2);
		acc(1'b0, ADDR_LINK_STAT, 32'h0, 32'h401C0, 32'h0, RESP_OKAY);
		acc(1'b1, ADDR_LINK_CTRL, 32'h200, 32'h0, 32'h0, RESP_OKAY);
		acc(1'b1, ADDR_PM_CTRL, 32'h3, 32'h0, 32'h0, RESP_OKAY);
		intr_pending <= 1'b1;
		acc(1'b0, ADDR_LINK_CTRL, 32'h0, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
		acc(1'b1, ADDR_LINK_CTRL, 32'h0, 32'h0, 32'h0, RESP_SLVERR);
		chk(irq, 1'b0);
		acc(1'b0, ADDR_PORT_CS, 32'h0, 32'h707, 32'h7, RESP_OKAY);
		chk(phy_tx[1].power_gate, 1'b1);
		acc(1'b1, ADDR_PM_CTRL, 32'h0, 32'h0, 32'h0, RESP_OKAY);
		repeat (2) @(negedge sys_clk);
		chk(irq, 1'b1);
		acc(1'b0, ADDR_LINK_CTRL, 32'h0, 32'hFFFFFFFF, 32'h200, RESP_OKAY);
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
